// [output_mux_divider_power_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none

// Contract
// - sync one holds every output divider reset
// - sync falling releases all, skew cleared together
// - outputs ten/eleven: zero J, one I
// - outputs eight/nine: zero I, one J
// - output seven: zero H, one G
// - output six: zero G, one H
// - output five: zero F, one E
// - output four: zero E, one F
// - output three: zero D, one A
// - output two: zero C, one A
// - output one: zero B, one A
// - power-down bit one stops its divider
module output_mux_divider_power_ctrl
(
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire outmux_pkg::reg_req_s REG_REQ_I,
   output logic [7:0] RD_DATA_O,
   output logic RD_VALID_O,
   output logic DIV_HOLD_O,
   output logic DIV_RELEASE_O,
   output logic [7:0] DIV_PWRDN_O,
   output logic [6:0][2:0] FRAC_SRC_O,
   output logic INT_SRC_Q8_9_O,
   output logic INT_SRC_Q10_11_O
);

   logic [7:0] int_sel_r;
   logic [7:0] int_sel_nxt;
   logic [7:0] frac_sel_r;
   logic [7:0] frac_sel_nxt;
   logic [7:0] pwr_r;
   logic [7:0] pwr_nxt;
   logic release_r;
   logic release_nxt;
   logic [7:0] rd_data_r;
   logic [7:0] rd_data_nxt;
   logic rd_valid_r;
   logic [6:0][2:0] frac_src_r;
   logic [6:0][2:0] frac_src_nxt;
   logic q89_r;
   logic q1011_r;
   wire wr_int;
   wire wr_frac;
   wire wr_pwr;
   wire hit_int;
   wire hit_frac;
   wire hit_pwr;

   // exact address match; partial decoding would alias unmapped addresses onto live registers
   function automatic logic hit(input logic [15:0] addr, input logic [15:0] target);
      hit = (addr == target);
   endfunction

   // pick one of two divider codes from a select bit
   function automatic outmux_pkg::frac_div_t pick(input logic sel, input outmux_pkg::frac_div_t src0,
                                                  input outmux_pkg::frac_div_t src1);
      pick = sel ? src1 : src0;
   endfunction

   // address decode, shared by the write strobes and the read mux
   assign hit_int = hit(REG_REQ_I.addr, outmux_pkg::ADDR_INT_SEL);
   assign hit_frac = hit(REG_REQ_I.addr, outmux_pkg::ADDR_FRAC_SEL);
   assign hit_pwr = hit(REG_REQ_I.addr, outmux_pkg::ADDR_PWR_DOWN);

   // write decode; the reserved registers and unmapped addresses take no write at all
   assign wr_int = REG_REQ_I.wr && hit_int;
   assign wr_frac = REG_REQ_I.wr && hit_frac;
   assign wr_pwr = REG_REQ_I.wr && hit_pwr;

   // reserved bits are masked off, so a stray one written there is harmless
   assign int_sel_nxt = wr_int ? (REG_REQ_I.wdata & outmux_pkg::INT_SEL_MASK) : int_sel_r;
   assign frac_sel_nxt = wr_frac ? (REG_REQ_I.wdata & outmux_pkg::FRAC_SEL_MASK) : frac_sel_r;
   assign pwr_nxt = wr_pwr ? (REG_REQ_I.wdata & outmux_pkg::PWR_MASK) : pwr_r;

   // one-cycle release when the sync bit falls; writing the same value twice does nothing
   assign release_nxt = int_sel_r[outmux_pkg::SYNC_BIT] & ~int_sel_nxt[outmux_pkg::SYNC_BIT];

   // read mux; reserved registers and unknown addresses read zero
   // a write in the same cycle is not bypassed, so a combined request reads the old value
   assign rd_data_nxt = hit_int ? int_sel_r :
                        hit_frac ? frac_sel_r :
                        hit_pwr ? pwr_r :
                        outmux_pkg::READ_ZERO;

   // per-output source decode for outputs 1..7
   genvar g;
   generate
      for (g = 0; g < 7; g++)
      begin : g_frac
         assign frac_src_nxt[g] = pick(frac_sel_r[g + 1], outmux_pkg::FRAC_SRC0[g],
                                       outmux_pkg::FRAC_SRC1[g]);
      end
   endgenerate

   // sync and integer selects; the sync bit is both the hold level and the release edge source
   always_ff @(posedge CLOCK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         int_sel_r <= outmux_pkg::INT_SEL_RST;
      end
      else
      begin
         int_sel_r <= int_sel_nxt;
      end
   end

   // fractional selects for outputs one to seven
   always_ff @(posedge CLOCK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         frac_sel_r <= outmux_pkg::FRAC_SEL_RST;
      end
      else
      begin
         frac_sel_r <= frac_sel_nxt;
      end
   end

   // power-down bits, one per fractional divider
   always_ff @(posedge CLOCK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         pwr_r <= outmux_pkg::PWR_RST;
      end
      else
      begin
         pwr_r <= pwr_nxt;
      end
   end

   // release pulse; a reset while held clears it, so reset never fakes a phase-aligned start
   always_ff @(posedge CLOCK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         release_r <= 1'b0;
      end
      else
      begin
         release_r <= release_nxt;
      end
   end

   // read data re-samples every cycle; only the valid pulse says when it means something
   always_ff @(posedge CLOCK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         rd_data_r <= outmux_pkg::READ_ZERO;
      end
      else
      begin
         rd_data_r <= rd_data_nxt;
      end
   end

   // read valid, high for the one cycle after the edge that took the read
   always_ff @(posedge CLOCK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         rd_valid_r <= 1'b0;
      end
      else
      begin
         rd_valid_r <= REG_REQ_I.rd;
      end
   end

   // registered fractional source codes; they trail the select bits by one cycle
   always_ff @(posedge CLOCK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         frac_src_r <= outmux_pkg::FRAC_SRC0;
      end
      else
      begin
         frac_src_r <= frac_src_nxt;
      end
   end

   // source of outputs eight and nine
   always_ff @(posedge CLOCK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         q89_r <= outmux_pkg::INT_DIV_I;
      end
      else
      begin
         q89_r <= int_sel_r[outmux_pkg::MUX_8_9_BIT] ? outmux_pkg::INT_DIV_J : outmux_pkg::INT_DIV_I;
      end
   end

   // source of outputs ten and eleven; its zero code selects the other integer divider
   always_ff @(posedge CLOCK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         q1011_r <= outmux_pkg::INT_DIV_J;
      end
      else
      begin
         q1011_r <= int_sel_r[outmux_pkg::MUX_10_11_BIT] ? outmux_pkg::INT_DIV_I : outmux_pkg::INT_DIV_J;
      end
   end

   // hold follows the sync bit itself, so all dividers leave reset on one edge
   assign DIV_HOLD_O = int_sel_r[outmux_pkg::SYNC_BIT];
   assign DIV_RELEASE_O = release_r;
   assign DIV_PWRDN_O = pwr_r;
   assign RD_DATA_O = rd_data_r;
   assign RD_VALID_O = rd_valid_r;
   assign FRAC_SRC_O = frac_src_r;
   assign INT_SRC_Q8_9_O = q89_r;
   assign INT_SRC_Q10_11_O = q1011_r;

endmodule

`default_nettype wire

// [outmux_pkg.sv]
package outmux_pkg;
   // register addresses
   localparam logic [15:0] ADDR_MUX_RSVD = 16'h008D;
   localparam logic [15:0] ADDR_INT_SEL = 16'h008E;
   localparam logic [15:0] ADDR_FRAC_SEL = 16'h008F;
   localparam logic [15:0] ADDR_PWR_RSVD = 16'h0090;
   localparam logic [15:0] ADDR_PWR_DOWN = 16'h0091;

   // field positions
   localparam int SYNC_BIT = 7;
   localparam int MUX_10_11_BIT = 1;
   localparam int MUX_8_9_BIT = 0;

   // writable bits of each register; the others are reserved
   localparam logic [7:0] INT_SEL_MASK = 8'h83;
   localparam logic [7:0] FRAC_SEL_MASK = 8'hFE;
   localparam logic [7:0] PWR_MASK = 8'hFF;

   // reset values
   localparam logic [7:0] INT_SEL_RST = 8'h00;
   localparam logic [7:0] FRAC_SEL_RST = 8'h00;
   localparam logic [7:0] PWR_RST = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // fractional divider codes, A..H
   typedef logic [2:0] frac_div_t;
   localparam frac_div_t DIV_A = 3'h0;
   localparam frac_div_t DIV_B = 3'h1;
   localparam frac_div_t DIV_C = 3'h2;
   localparam frac_div_t DIV_D = 3'h3;
   localparam frac_div_t DIV_E = 3'h4;
   localparam frac_div_t DIV_F = 3'h5;
   localparam frac_div_t DIV_G = 3'h6;
   localparam frac_div_t DIV_H = 3'h7;

   // integer divider codes
   localparam logic INT_DIV_I = 1'b0;
   localparam logic INT_DIV_J = 1'b1;

   // sources of outputs 1..7 (element 0 is output 1) for select zero and one
   localparam frac_div_t [6:0] FRAC_SRC0 = {DIV_H, DIV_G, DIV_F, DIV_E, DIV_D, DIV_C, DIV_B};
   localparam frac_div_t [6:0] FRAC_SRC1 = {DIV_G, DIV_H, DIV_E, DIV_F, DIV_A, DIV_A, DIV_A};

   // register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } reg_req_s;
endpackage

// [output_mux_divider_power_ctrl_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
// watches register writes and the divider controls they drive
module outmux_checker (
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire outmux_pkg::reg_req_s REG_REQ_I,
   input wire logic [7:0] RD_DATA_O,
   input wire logic RD_VALID_O,
   input wire logic DIV_HOLD_O,
   input wire logic DIV_RELEASE_O,
   input wire logic [7:0] DIV_PWRDN_O,
   input wire logic [6:0][2:0] FRAC_SRC_O,
   input wire logic INT_SRC_Q8_9_O,
   input wire logic INT_SRC_Q10_11_O
);
   wire [7:0] wd = REG_REQ_I.wdata;
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);
   // a write, or a read with no write beside it, taken at one address
   sequence s_w(logic [15:0] x); REG_REQ_I.wr && REG_REQ_I.addr == x; endsequence
   sequence s_r(logic [15:0] x); REG_REQ_I.rd && !REG_REQ_I.wr && REG_REQ_I.addr == x; endsequence
   property p_hold; s_w(16'h008E) |=> DIV_HOLD_O == $past(wd[7]); endproperty
   a_hold: assert property (p_hold) else $error("hold wrong");
   property p_rel; $fell(DIV_HOLD_O) |-> DIV_RELEASE_O; endproperty
   a_rel: assert property (p_rel) else $error("no release");
   property p_one; DIV_RELEASE_O |-> $past(DIV_HOLD_O) && !DIV_HOLD_O; endproperty
   a_one: assert property (p_one) else $error("stray release");
   property p_q10; s_w(16'h008E) |=> ##1 INT_SRC_Q10_11_O == !$past(wd[1], 2); endproperty
   a_q10: assert property (p_q10) else $error("q10 source");
   property p_q8; s_w(16'h008E) |=> ##1 INT_SRC_Q8_9_O == $past(wd[0], 2); endproperty
   a_q8: assert property (p_q8) else $error("q8 source");
   property p_pwr; s_w(16'h0091) |=> DIV_PWRDN_O == $past(wd); endproperty
   a_pwr: assert property (p_pwr) else $error("power-down");
   property p_rd; s_r(16'h0091) |=> RD_VALID_O && RD_DATA_O == DIV_PWRDN_O; endproperty
   a_rd: assert property (p_rd) else $error("read back");
   // sources trail the select register by one more stage
   for (genvar k = 0; k < 7; k++)
   begin : g_src
      property p_src; s_w(16'h008F) |=> ##1 FRAC_SRC_O[k] ==
         ($past(wd[k + 1], 2) ? outmux_pkg::FRAC_SRC1[k] : outmux_pkg::FRAC_SRC0[k]); endproperty
      a_src: assert property (p_src) else $error("frac source");
   end
endmodule
bind output_mux_divider_power_ctrl outmux_checker u_chk (
   .CLOCK_I(CLOCK_I),
   .RST_N_I(RST_N_I),
   .REG_REQ_I(REG_REQ_I),
   .RD_DATA_O(RD_DATA_O),
   .RD_VALID_O(RD_VALID_O),
   .DIV_HOLD_O(DIV_HOLD_O),
   .DIV_RELEASE_O(DIV_RELEASE_O),
   .DIV_PWRDN_O(DIV_PWRDN_O),
   .FRAC_SRC_O(FRAC_SRC_O),
   .INT_SRC_Q8_9_O(INT_SRC_Q8_9_O),
   .INT_SRC_Q10_11_O(INT_SRC_Q10_11_O)
);
`default_nettype wire

// [tb_output_mux_divider_power_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_output_mux_divider_power_ctrl;
   logic CLOCK_I = 1'b0;
   logic RST_N_I = 1'b0;
   outmux_pkg::reg_req_s REG_REQ_I = '0;
   wire [7:0] RD_DATA_O, DIV_PWRDN_O;
   wire RD_VALID_O, DIV_HOLD_O, DIV_RELEASE_O, INT_SRC_Q8_9_O, INT_SRC_Q10_11_O;
   wire [6:0][2:0] FRAC_SRC_O;
   int num_errors = 0;
   int n_tests = 0;
   // address, write data, read back, outputs; each row builds on the last
   logic [63:0] rows [7] = '{64'h008FFEFE401BCA00, 64'h008F0100401F58D1, 64'h008E0303201F58D1,
      64'h0091A5A534BF58D1, 64'h008DFF0034BF58D1, 64'h0090FF0034BF58D1, 64'h018EFF0034BF58D1};
   wire [31:0] obs = {DIV_HOLD_O, INT_SRC_Q10_11_O, INT_SRC_Q8_9_O, DIV_PWRDN_O, FRAC_SRC_O};
   output_mux_divider_power_ctrl DUT (
      .CLOCK_I(CLOCK_I),
      .RST_N_I(RST_N_I),
      .REG_REQ_I(REG_REQ_I),
      .RD_DATA_O(RD_DATA_O),
      .RD_VALID_O(RD_VALID_O),
      .DIV_HOLD_O(DIV_HOLD_O),
      .DIV_RELEASE_O(DIV_RELEASE_O),
      .DIV_PWRDN_O(DIV_PWRDN_O),
      .FRAC_SRC_O(FRAC_SRC_O),
      .INT_SRC_Q8_9_O(INT_SRC_Q8_9_O),
      .INT_SRC_Q10_11_O(INT_SRC_Q10_11_O)
   );
   always #20 CLOCK_I = ~CLOCK_I;
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e)
      begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, s, e);
      end
   endtask
   // one strobe, dropped after the edge that takes it
   task req(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge CLOCK_I) #1 REG_REQ_I = {w, !w, a, d};
      @(posedge CLOCK_I) #1 REG_REQ_I = '0;
   endtask
   task stop_test;
      $display("errors %0d in %0d checks", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(posedge CLOCK_I);
      #1 chk(obs, 32'h401F58D1);
      chk({RD_VALID_O, RD_DATA_O}, 32'h0);
      RST_N_I = 1'b1;
      foreach (rows[i])
      begin
         req(1'b1, rows[i][63:48], rows[i][47:40]);
         req(1'b0, rows[i][63:48], 8'h00);
         chk({RD_VALID_O, RD_DATA_O}, {1'b1, rows[i][39:32]});
         chk(obs, rows[i][31:0]);
      end
      // hold, hold again with no pulse, then a single release pulse
      req(1'b1, 16'h008E, 8'h80);
      chk({DIV_HOLD_O, DIV_RELEASE_O}, 2'b10);
      req(1'b1, 16'h008E, 8'h80);
      chk({DIV_HOLD_O, DIV_RELEASE_O}, 2'b10);
      req(1'b1, 16'h008E, 8'h00);
      chk({DIV_HOLD_O, DIV_RELEASE_O}, 2'b01);
      @(posedge CLOCK_I) #1 chk({DIV_HOLD_O, DIV_RELEASE_O}, 2'b00);
      // mid-run reset while held, over two edges: all back to reset values, no release
      req(1'b1, 16'h008E, 8'h80);
      RST_N_I = 1'b0;
      #1 chk(obs, 32'h401F58D1);
      chk({RD_VALID_O, RD_DATA_O, DIV_RELEASE_O}, 32'h0);
      repeat (2) @(posedge CLOCK_I);
      #1 RST_N_I = 1'b1;
      // first request taken on the first edge after release
      REG_REQ_I = {1'b1, 1'b0, 16'h008E, 8'h80};
      @(posedge CLOCK_I) #1 REG_REQ_I = '0;
      chk(obs, 32'hC01F58D1);
      chk(DIV_RELEASE_O, 1'b0);
      // write and read in one request: the read answers with the old value
      @(posedge CLOCK_I) #1 REG_REQ_I = {1'b1, 1'b1, 16'h0091, 8'h3C};
      @(posedge CLOCK_I) #1 REG_REQ_I = '0;
      chk({RD_VALID_O, RD_DATA_O}, {1'b1, 8'h00});
      chk(DIV_PWRDN_O, 8'h3C);
      @(posedge CLOCK_I) #1 chk(RD_VALID_O, 1'b0);
      // release once, then a second zero write gives no pulse
      req(1'b1, 16'h008E, 8'h00);
      chk({RD_VALID_O, DIV_HOLD_O, DIV_RELEASE_O}, 3'b001);
      req(1'b1, 16'h008E, 8'h00);
      chk({DIV_HOLD_O, DIV_RELEASE_O}, 2'b00);
      stop_test;
   end
endmodule
`default_nettype wire
